// >>> bench/vdc_control_regs_tb.sv
// Self-checking bench for the video decoder register bank
`timescale 1ns/1ps
module vdc_control_regs_tb;
   logic clk = 1'b0, rst_n = 1'b0, syncOn = 1'b1, chkPix = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, detectBusy = 1'b0;
   logic wssValid = 1'b0, wssCrcErr = 1'b1, wssFieldEven = 1'b1;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [2:0] detectedStd = 3'h0;
   logic [5:0] stat = 6'h2D;
   logic [13:0] wssBits = 14'h2ABC;
   logic [1:0] s_axi_bresp, s_axi_rresp, chroma_input_select;
   logic [1:0] decode_type_select, luma_input_select;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, horiz_pll_locked, subcarrier_locked, fieldEven;
   logic vert_logic_locked, burstSeen, fifty_hz_flag, hsyncLead, vsyncLead;
   logic lineTick, pixValid, pixOutValid, activeVideo, video_absent_flag;
   logic chromaNone, crystal_rate_select, vchan_input_select, softResetPulse;
   logic gain_loop_disable, clock_powerdown, luma_conv_powerdown;
   logic chroma_conv_powerdown, vchan_conv_powerdown, combAdaptive;
   logic no_burst_comb_off, pal_delay_disable, setup_pedestal_on;
   logic widescreen_decode_on;
   logic [4:0] caption_odd_line;
   logic [7:0] fixed_gain_value;
   logic [9:0] pixIn, pixOut, prevPix, vDelay, vActive, hDelay, hActive;
   int n_fail = 0, num_checks = 0;
   // Arbitrary identity values
   vdc_control_regs #(.PRODUCT_CODE(5'h0B), .REVISION_CODE(3'h5)) dut_u (.*);
   vdc_video_src src_u (.*);
   // Status levels from one vector
   assign {horiz_pll_locked, subcarrier_locked, fieldEven, vert_logic_locked,
      burstSeen, fifty_hz_flag} = stat;
   always #2.5 clk = ~clk;
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [9:0] i, logic [7:0] d, logic [1:0] r = 0);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      do @(posedge clk); while (!s_axi_awready);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h1;
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, r);
   endtask : wr
   task automatic rd(input logic [9:0] i, logic [7:0] e, logic [1:0] r = 0);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      {s_axi_arvalid, s_axi_rready} <= 2'h1;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk({s_axi_rresp, s_axi_rdata}, {r, 24'h0, e});
   endtask : rd
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   // Output pixel against gain two and offset minus eight
   always @(posedge clk) begin
      if (chkPix && pixOutValid) begin
         chk(pixOut, prevPix < 4 ? 0 : prevPix * 2 - 8);
         chk(activeVideo, 1'b1);
      end
      prevPix <= pixIn;
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(10'h011, 8'h5C);
      wr(10'h000, 8'h00, 2'h2);
      rd(10'h000, {5'h0B, 3'h5});
      rd(10'h100, 8'h00, 2'h2);
      rd(10'h001, 8'h5B);
      stat <= 6'h12;
      rd(10'h001, 8'h20);
      syncOn <= 1'b0;
      repeat (60) @(posedge clk);
      rd(10'h001, 8'hA0);
      syncOn <= 1'b1;
      repeat (20) @(posedge clk);
      rd(10'h001, 8'h20);
      wr(10'h002, 8'hBD);
      chk({chroma_input_select, crystal_rate_select, decode_type_select,
         luma_input_select, vchan_input_select}, 8'h9F);
      wr(10'h002, 8'h82);
      chk(chromaNone, 1'b1);
      wr(10'h006, 8'h9F);
      rd(10'h006, 8'h1F);
      chk({gain_loop_disable, clock_powerdown, luma_conv_powerdown,
         chroma_conv_powerdown, vchan_conv_powerdown, fixed_gain_value},
         13'h1FF0);
      wr(10'h007, 8'hE4);
      chk({vDelay, vActive, hDelay}, {10'h312, 10'h220, 10'h110});
      chk(hActive, 10'h0D0);
      wr(10'h01C, 8'h01);
      wr(10'h009, 8'h33);
      wr(10'h00A, 8'h44);
      wr(10'h01C, 8'h00);
      rd(10'h009, 8'h20);
      rd(10'h00A, 8'h10);
      wr(10'h01C, 8'h02);
      rd(10'h009, 8'h33);
      rd(10'h00A, 8'h10);
      wr(10'h01C, 8'h04);
      rd(10'h00A, 8'h44);
      wr(10'h01C, 8'h09);
      rd(10'h00A, 8'h10);
      wr(10'h00C, 8'h1B);
      wr(10'h00D, 8'h2A);
      chk({combAdaptive, no_burst_comb_off, pal_delay_disable,
         setup_pedestal_on, widescreen_decode_on, caption_odd_line},
         10'h3EA);
      wssValid <= 1'b1;
      @(posedge clk);
      wssValid <= 1'b0;
      rd(10'h00E, 8'hEA);
      rd(10'h00F, 8'hBC);
      wr(10'h010, 8'hFE);
      wr(10'h011, 8'h80);
      wr(10'h007, 8'h00);
      wr(10'h008, 8'h00);
      wr(10'h00A, 8'h00);
      chkPix <= 1'b1;
      repeat (40) @(posedge clk);
      end_of_test();
   end
   // Cut a hung run short
   initial begin
      #50000;
      n_fail++;
      end_of_test();
   end
endmodule : vdc_control_regs_tb
bind vdc_control_regs vdc_regs_monitor mon_u (.*);

// >>> bench/vdc_regs_monitor.sv
// Port checker for the register bank
`timescale 1ns/1ps
module vdc_regs_monitor (
   // Clock, reset and bus
   input wire logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_bvalid,
   input wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp, chroma_input_select,
   input wire logic [31:0] s_axi_rdata,
   // Decoder side
   input wire logic chromaNone, softResetPulse, hsyncLead, lineTick,
   input wire logic video_absent_flag, pixValid, pixOutValid, activeVideo
);
   // One clock domain, quiet in reset
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      |=> s_axi_bvalid) else $error("write not answered");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read not answered");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   a_chroma_none: assert property (
      chromaNone == (chroma_input_select == 2'h3)) else $error("chroma");
   a_soft_single: assert property (softResetPulse
      |=> !softResetPulse && !video_absent_flag) else $error("soft reset");
   a_absent_clear: assert property (hsyncLead && !lineTick
      |=> !video_absent_flag) else $error("loss flag stuck");
   a_pix_latency: assert property (pixValid && !softResetPulse
      |=> pixOutValid) else $error("pixel late");
   a_active_valid: assert property (activeVideo
      |-> pixOutValid) else $error("active without pixel");
endmodule : vdc_regs_monitor

// >>> bench/vdc_video_src.sv
// Behavioural video source: line ticks, sync and a pixel ramp
`timescale 1ns/1ps
module vdc_video_src (
   // Clock, reset and sync enable
   input wire logic clk, rst_n, syncOn,
   // Timing and pixels
   output logic hsyncLead, vsyncLead, lineTick, pixValid,
   output logic [9:0] pixIn
);
   logic [5:0] cnt;
   logic [7:0] pix;
   // Eight-cycle lines, eight lines a frame
   always_ff @(posedge clk) begin
      cnt <= rst_n ? cnt + 6'h1 : 6'h0;
      pix <= rst_n ? pix + {7'h0, pixValid} : 8'h0;
   end
   // Sync one cycle after the tick; idle data is scrambled
   assign lineTick = rst_n && cnt[2:0] == 3'h0;
   assign hsyncLead = syncOn && cnt[2:0] == 3'h1;
   assign vsyncLead = hsyncLead && cnt[5:3] == 3'h0;
   assign pixValid = cnt[2:0] > 3'h1;
   assign pixIn = pixValid ? {2'h0, pix} : {2'h3, ~pix};
endmodule : vdc_video_src

// >>> design/vdc_control_regs.sv
// Video decoder control and status register bank with its datapath hooks
// Functional notes
// - Identity register reads fixed product code in bits 7-3, revision 2-0.
// - Video-absent flag sets after missing-count line periods without sync.
// - Status bits 6, 5, 3 show horizontal, subcarrier, vertical lock.
// - Status bit 4 shows decoded field: 0 odd, 1 even.
// - Status bit 1 flags missing burst; bit 0 set for 50 Hz source.
// - Chroma input code from format bits 7 and 1; 11 selects none.
// - Format bit 6 selects 27 MHz crystal, else square-pixel clocks.
// - Format bits 5-4 pick composite, S-video or component decoding.
// - Format bits 3-2 pick luma input; bit 0 picks V-channel input.
// - Soft reset bit restarts logic, clears widescreen status bytes, keeps control registers, clears itself.
// - Analog bit 4 disables gain loop and applies fixed gain value.
// - Analog bits 3-0 power down clock, luma, chroma, V converters.
// - Four 10-bit crop values: low bytes plus shared high register.
// - Active window starts after delays and spans the active counts.
// - 50 Hz vertical-active copy is reached once a 50 Hz standard is set.
// - PAL and SECAM horizontal-delay copies follow the selected standard.
// - Filter bit 3 comb or notch, bit 1 no-burst comb off, bit 0.
// - Filter bit 4 places black 7.5 IRE above blank.
// - Caption bit 5 enables widescreen decode; bits 4-0 caption line.
// - Widescreen status bytes hold sliced bits, CRC error and field.
// - Brightness adds a signed two's-complement offset; zero is neutral.
// - Contrast is unsigned gain, 0x40 gives unity.
// - Standard register shadow-disable bit 3 turns shadow copies off.
`timescale 1ns/1ps
module vdc_control_regs #(
   parameter logic [4:0] PRODUCT_CODE = 5'h15, // Arbitrary value
   parameter logic [2:0] REVISION_CODE = 3'h3, // Arbitrary value
   parameter int PIX_W = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AXI4-Lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Decoder status inputs
   input wire logic horiz_pll_locked,
   input wire logic subcarrier_locked,
   input wire logic vert_logic_locked,
   input wire logic fieldEven,
   input wire logic burstSeen,
   input wire logic fifty_hz_flag,
   input wire logic detectBusy,
   input wire logic [2:0] detectedStd,
   // Sync and line timing
   input wire logic hsyncLead,
   input wire logic vsyncLead,
   input wire logic lineTick,
   // Widescreen slicer
   input wire logic wssValid,
   input wire logic [13:0] wssBits,
   input wire logic wssCrcErr,
   input wire logic wssFieldEven,
   // Pixel stream
   input wire logic pixValid,
   input wire logic [PIX_W-1:0] pixIn,
   output logic pixOutValid,
   output logic [PIX_W-1:0] pixOut,
   output logic activeVideo,
   // Decoder configuration outputs
   output logic video_absent_flag,
   output logic [1:0] chroma_input_select,
   output logic chromaNone,
   output logic crystal_rate_select,
   output logic [1:0] decode_type_select,
   output logic [1:0] luma_input_select,
   output logic vchan_input_select,
   output logic softResetPulse,
   output logic gain_loop_disable,
   output logic [7:0] fixed_gain_value,
   output logic clock_powerdown,
   output logic luma_conv_powerdown,
   output logic chroma_conv_powerdown,
   output logic vchan_conv_powerdown,
   output logic combAdaptive,
   output logic no_burst_comb_off,
   output logic pal_delay_disable,
   output logic setup_pedestal_on,
   output logic widescreen_decode_on,
   output logic [4:0] caption_odd_line,
   output logic [9:0] vDelay,
   output logic [9:0] vActive,
   output logic [9:0] hDelay,
   output logic [9:0] hActive
);

   // ****************************************
   // Helper functions
   // ****************************************

   // Count lies inside a window of given start and length
   function automatic logic inWindow(input logic [10:0] cnt,
                                     input logic [9:0] start,
                                     input logic [9:0] len);
      logic [10:0] stop;
      stop = {1'b0, start} + {1'b0, len};
      return (cnt >= {1'b0, start}) && (cnt < stop);
   endfunction : inWindow

   // Standard runs at 50 Hz field rate
   function automatic logic is50Hz(input logic [2:0] std);
      return (std == vdc_pkg::STD_PAL_BDGHI) ||
         (std == vdc_pkg::STD_SECAM) || (std == vdc_pkg::STD_PAL_CN);
   endfunction : is50Hz

   // ****************************************
   // Register storage
   // ****************************************
   logic [7:0] inputFormat, syncDelayCtrl, analogCtrl, cropHigh;
   logic [7:0] vDelayLow, vActiveLow, vActive50Low, hActiveLow;
   logic [7:0] hDelayLow, hDelayPalLow, hDelaySecamLow;
   logic [7:0] filterCtrl, captionCtrl, brightness, contrast;
   logic [7:0] sharpCtrl, stdSelect, fixedGain, missingLineCount;
   logic [7:0] wssHigh, wssLow;
   logic [2:0] effStd;
   logic useShadow, sel50, selPal, selSecam;

   // Standard in force and which shadow copy is reached
   assign effStd = (stdSelect[2:0] == vdc_pkg::STD_AUTO) ? detectedStd :
      stdSelect[2:0];
   assign useShadow = !stdSelect[vdc_pkg::BIT_SHADOW_DISABLE];
   assign sel50 = useShadow && is50Hz(effStd);
   assign selSecam = useShadow && (effStd == vdc_pkg::STD_SECAM);
   assign selPal = useShadow && !selSecam && (effStd != 3'h0) &&
      (effStd != 3'h3);

   // ****************************************
   // AXI4-Lite write channel
   // ****************************************
   logic wrFire;
   logic [9:0] wrIdx;
   logic [7:0] wrByte;
   logic wrMapped;

   // Address and data are taken together, one write at a time
   assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_wready = s_axi_awready;
   assign wrFire = s_axi_awready;
   assign wrIdx = s_axi_awaddr[11:2];
   assign wrByte = s_axi_wdata[7:0];

   // Writable index decode
   always_comb begin
      unique case (wrIdx)
         vdc_pkg::IDX_INPUT_FORMAT_SELECT, vdc_pkg::IDX_RESERVED_THREE,
         vdc_pkg::IDX_SYNC_DELAY_KILLER_CTRL, vdc_pkg::IDX_RESERVED_FIVE,
         vdc_pkg::IDX_ANALOG_POWER_CTRL, vdc_pkg::IDX_CROP_HIGH_BITS,
         vdc_pkg::IDX_VERTICAL_DELAY_LOW, vdc_pkg::IDX_VERTICAL_ACTIVE_LOW,
         vdc_pkg::IDX_HORIZONTAL_DELAY_LOW,
         vdc_pkg::IDX_HORIZONTAL_ACTIVE_LOW, vdc_pkg::IDX_FILTER_CONTROL_ONE,
         vdc_pkg::IDX_CAPTION_CONTROL, vdc_pkg::IDX_BRIGHTNESS_OFFSET,
         vdc_pkg::IDX_CONTRAST_GAIN, vdc_pkg::IDX_SHARPNESS_CONTROL,
         vdc_pkg::IDX_STANDARD_SELECT, vdc_pkg::IDX_FIXED_GAIN,
         vdc_pkg::IDX_MISSING_COUNT: wrMapped = 1'b1;
         default: wrMapped = 1'b0;
      endcase
   end

   // Register writes, low byte lane only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         inputFormat <= vdc_pkg::RST_INPUT_FORMAT;
         syncDelayCtrl <= 8'h00;
         analogCtrl <= vdc_pkg::RST_ANALOG_CTRL;
         cropHigh <= vdc_pkg::RST_CROP_HIGH;
         vDelayLow <= vdc_pkg::RST_VDELAY_LOW;
         vActiveLow <= vdc_pkg::RST_VACTIVE_LOW;
         vActive50Low <= vdc_pkg::RST_VACTIVE_LOW;
         hDelayLow <= vdc_pkg::RST_HDELAY_LOW;
         hDelayPalLow <= vdc_pkg::RST_HDELAY_LOW;
         hDelaySecamLow <= vdc_pkg::RST_HDELAY_LOW;
         hActiveLow <= vdc_pkg::RST_HACTIVE_LOW;
         filterCtrl <= vdc_pkg::RST_FILTER_CTRL;
         captionCtrl <= vdc_pkg::RST_CAPTION_CTRL;
         brightness <= vdc_pkg::RST_BRIGHTNESS;
         contrast <= vdc_pkg::RST_CONTRAST;
         sharpCtrl <= 8'h00;
         stdSelect <= vdc_pkg::RST_STANDARD;
         fixedGain <= vdc_pkg::RST_FIXED_GAIN;
         missingLineCount <= vdc_pkg::RST_MISSING_COUNT;
      end else if (wrFire && s_axi_wstrb[0]) begin
         unique case (wrIdx)
            vdc_pkg::IDX_INPUT_FORMAT_SELECT: inputFormat <= wrByte;
            vdc_pkg::IDX_SYNC_DELAY_KILLER_CTRL: syncDelayCtrl <= wrByte;
            // Soft reset bit is never stored
            vdc_pkg::IDX_ANALOG_POWER_CTRL: analogCtrl <= {1'b0, wrByte[6:0]};
            vdc_pkg::IDX_CROP_HIGH_BITS: cropHigh <= wrByte;
            vdc_pkg::IDX_VERTICAL_DELAY_LOW: vDelayLow <= wrByte;
            vdc_pkg::IDX_VERTICAL_ACTIVE_LOW: begin
               if (sel50) begin
                  vActive50Low <= wrByte;
               end else begin
                  vActiveLow <= wrByte;
               end
            end
            vdc_pkg::IDX_HORIZONTAL_DELAY_LOW: begin
               if (selSecam) begin
                  hDelaySecamLow <= wrByte;
               end else if (selPal) begin
                  hDelayPalLow <= wrByte;
               end else begin
                  hDelayLow <= wrByte;
               end
            end
            vdc_pkg::IDX_HORIZONTAL_ACTIVE_LOW: hActiveLow <= wrByte;
            vdc_pkg::IDX_FILTER_CONTROL_ONE: filterCtrl <= wrByte;
            vdc_pkg::IDX_CAPTION_CONTROL: captionCtrl <= wrByte;
            vdc_pkg::IDX_BRIGHTNESS_OFFSET: brightness <= wrByte;
            vdc_pkg::IDX_CONTRAST_GAIN: contrast <= wrByte;
            vdc_pkg::IDX_SHARPNESS_CONTROL: sharpCtrl <= wrByte;
            vdc_pkg::IDX_STANDARD_SELECT: stdSelect <= {4'h0, wrByte[3:0]};
            vdc_pkg::IDX_FIXED_GAIN: fixedGain <= wrByte;
            vdc_pkg::IDX_MISSING_COUNT: missingLineCount <= wrByte;
            default: ;
         endcase
      end
   end

   // Soft reset pulse, one cycle, control registers untouched
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         softResetPulse <= 1'b0;
      end else begin
         softResetPulse <= wrFire && s_axi_wstrb[0] &&
            (wrIdx == vdc_pkg::IDX_ANALOG_POWER_CTRL) &&
            wrByte[vdc_pkg::BIT_SOFT_RESET];
      end
   end

   // Write response
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= vdc_pkg::RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrMapped ? vdc_pkg::RESP_OKAY : vdc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   logic [7:0] rdByte;
   logic rdMapped;
   logic [7:0] statusByte;

   assign s_axi_arready = !s_axi_rvalid;
   assign statusByte = {video_absent_flag, horiz_pll_locked,
      subcarrier_locked, fieldEven, vert_logic_locked, 1'b0, !burstSeen,
      fifty_hz_flag};

   // Read multiplexer
   always_comb begin
      rdMapped = 1'b1;
      unique case (s_axi_araddr[11:2])
         vdc_pkg::IDX_PRODUCT_IDENTITY:
            rdByte = {PRODUCT_CODE, REVISION_CODE};
         vdc_pkg::IDX_DECODER_STATUS: rdByte = statusByte;
         vdc_pkg::IDX_INPUT_FORMAT_SELECT: rdByte = inputFormat;
         vdc_pkg::IDX_SYNC_DELAY_KILLER_CTRL: rdByte = syncDelayCtrl;
         vdc_pkg::IDX_ANALOG_POWER_CTRL: rdByte = analogCtrl;
         vdc_pkg::IDX_CROP_HIGH_BITS: rdByte = cropHigh;
         vdc_pkg::IDX_VERTICAL_DELAY_LOW: rdByte = vDelayLow;
         vdc_pkg::IDX_VERTICAL_ACTIVE_LOW:
            rdByte = sel50 ? vActive50Low : vActiveLow;
         vdc_pkg::IDX_HORIZONTAL_DELAY_LOW:
            rdByte = selSecam ? hDelaySecamLow :
               (selPal ? hDelayPalLow : hDelayLow);
         vdc_pkg::IDX_HORIZONTAL_ACTIVE_LOW: rdByte = hActiveLow;
         vdc_pkg::IDX_FILTER_CONTROL_ONE: rdByte = filterCtrl;
         vdc_pkg::IDX_CAPTION_CONTROL: rdByte = captionCtrl;
         vdc_pkg::IDX_WIDESCREEN_STATUS_HIGH: rdByte = wssHigh;
         vdc_pkg::IDX_WIDESCREEN_STATUS_LOW: rdByte = wssLow;
         vdc_pkg::IDX_BRIGHTNESS_OFFSET: rdByte = brightness;
         vdc_pkg::IDX_CONTRAST_GAIN: rdByte = contrast;
         vdc_pkg::IDX_SHARPNESS_CONTROL: rdByte = sharpCtrl;
         vdc_pkg::IDX_STANDARD_SELECT:
            rdByte = {detectBusy, detectedStd, stdSelect[3:0]};
         vdc_pkg::IDX_FIXED_GAIN: rdByte = fixedGain;
         vdc_pkg::IDX_MISSING_COUNT: rdByte = missingLineCount;
         vdc_pkg::IDX_RESERVED_THREE, vdc_pkg::IDX_RESERVED_FIVE:
            rdByte = 8'h00;
         default: begin
            rdByte = 8'h00;
            rdMapped = 1'b0;
         end
      endcase
   end

   // Read data registered one cycle after the address is taken
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= vdc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rdByte};
         s_axi_rresp <= rdMapped ? vdc_pkg::RESP_OKAY : vdc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // Status capture
   // ****************************************
   logic [7:0] missRun;

   // Video-absent detection from line periods without sync
   always_ff @(posedge clk) begin
      if (!rst_n || softResetPulse) begin
         missRun <= 8'h00;
         video_absent_flag <= 1'b0;
      end else if (hsyncLead) begin
         missRun <= 8'h00;
         video_absent_flag <= 1'b0;
      end else if (lineTick) begin
         if (missRun != 8'hFF) begin
            missRun <= missRun + 8'h01;
         end
         if (missRun + 8'h01 >= missingLineCount) begin
            video_absent_flag <= 1'b1;
         end
      end
   end

   // Widescreen slicer capture, only while decoding is on
   always_ff @(posedge clk) begin
      if (!rst_n || softResetPulse) begin
         wssHigh <= 8'h00;
         wssLow <= 8'h00;
      end else if (wssValid && widescreen_decode_on) begin
         wssHigh <= {wssCrcErr, wssFieldEven, wssBits[13:8]};
         wssLow <= wssBits[7:0];
      end
   end

   // ****************************************
   // Configuration outputs
   // ****************************************
   assign chroma_input_select = {inputFormat[7], inputFormat[1]};
   assign chromaNone = &chroma_input_select;
   assign crystal_rate_select = inputFormat[6];
   assign decode_type_select = inputFormat[5:4];
   assign luma_input_select = inputFormat[3:2];
   assign vchan_input_select = inputFormat[0];
   assign gain_loop_disable = analogCtrl[4];
   assign fixed_gain_value = fixedGain;
   assign clock_powerdown = analogCtrl[3];
   assign luma_conv_powerdown = analogCtrl[2];
   assign chroma_conv_powerdown = analogCtrl[1];
   assign vchan_conv_powerdown = analogCtrl[0];
   assign combAdaptive = filterCtrl[3];
   assign no_burst_comb_off = filterCtrl[1];
   assign pal_delay_disable = filterCtrl[0];
   assign setup_pedestal_on = filterCtrl[4];
   assign widescreen_decode_on = captionCtrl[5];
   assign caption_odd_line = captionCtrl[4:0];

   // Ten-bit crop values, shadow copy chosen by standard
   assign vDelay = {cropHigh[7:6], vDelayLow};
   assign vActive = {cropHigh[5:4],
      sel50 ? vActive50Low : vActiveLow};
   assign hDelay = {cropHigh[3:2], selSecam ? hDelaySecamLow :
      (selPal ? hDelayPalLow : hDelayLow)};
   assign hActive = {cropHigh[1:0], hActiveLow};

   // ****************************************
   // Crop window and picture adjust
   // ****************************************
   logic [10:0] pixCnt, lineCnt;
   logic [PIX_W+7:0] scaled;
   logic signed [PIX_W+8:0] adjusted;

   // Pixel and line counters from sync leading edges
   always_ff @(posedge clk) begin
      if (!rst_n || softResetPulse) begin
         pixCnt <= 11'h000;
         lineCnt <= 11'h000;
      end else begin
         if (hsyncLead) begin
            pixCnt <= 11'h000;
         end else if (pixValid && pixCnt != 11'h7FF) begin
            pixCnt <= pixCnt + 11'h001;
         end
         if (vsyncLead) begin
            lineCnt <= 11'h000;
         end else if (hsyncLead && lineCnt != 11'h7FF) begin
            lineCnt <= lineCnt + 11'h001;
         end
      end
   end

   // Contrast gain then brightness offset, clamped to range
   always_comb begin
      scaled = (PIX_W + 8)'(pixIn * contrast) >> vdc_pkg::CONTRAST_SHIFT;
      adjusted = $signed({1'b0, scaled}) +
         (PIX_W + 9)'($signed({brightness, 2'b00}));
   end

   // Registered pixel output with active flag
   always_ff @(posedge clk) begin
      if (!rst_n || softResetPulse) begin
         pixOut <= '0;
         pixOutValid <= 1'b0;
         activeVideo <= 1'b0;
      end else begin
         pixOutValid <= pixValid;
         activeVideo <= pixValid && inWindow(pixCnt, hDelay, hActive) &&
            inWindow(lineCnt, vDelay, vActive);
         if (adjusted < 0) begin
            pixOut <= '0;
         end else if (adjusted > $signed({9'h000, {PIX_W{1'b1}}})) begin
            pixOut <= '1;
         end else begin
            pixOut <= adjusted[PIX_W-1:0];
         end
      end
   end

endmodule : vdc_control_regs

// >>> design/vdc_pkg.sv
// Package with register map, field positions and reset values
package vdc_pkg;
   // ****************************************
   // Register indexes (byte address is index times four)
   // ****************************************
   localparam logic [9:0] IDX_PRODUCT_IDENTITY = 10'h000;
   localparam logic [9:0] IDX_DECODER_STATUS = 10'h001;
   localparam logic [9:0] IDX_INPUT_FORMAT_SELECT = 10'h002;
   localparam logic [9:0] IDX_RESERVED_THREE = 10'h003;
   localparam logic [9:0] IDX_SYNC_DELAY_KILLER_CTRL = 10'h004;
   localparam logic [9:0] IDX_RESERVED_FIVE = 10'h005;
   localparam logic [9:0] IDX_ANALOG_POWER_CTRL = 10'h006;
   localparam logic [9:0] IDX_CROP_HIGH_BITS = 10'h007;
   localparam logic [9:0] IDX_VERTICAL_DELAY_LOW = 10'h008;
   localparam logic [9:0] IDX_VERTICAL_ACTIVE_LOW = 10'h009;
   localparam logic [9:0] IDX_HORIZONTAL_DELAY_LOW = 10'h00A;
   localparam logic [9:0] IDX_HORIZONTAL_ACTIVE_LOW = 10'h00B;
   localparam logic [9:0] IDX_FILTER_CONTROL_ONE = 10'h00C;
   localparam logic [9:0] IDX_CAPTION_CONTROL = 10'h00D;
   localparam logic [9:0] IDX_WIDESCREEN_STATUS_HIGH = 10'h00E;
   localparam logic [9:0] IDX_WIDESCREEN_STATUS_LOW = 10'h00F;
   localparam logic [9:0] IDX_BRIGHTNESS_OFFSET = 10'h010;
   localparam logic [9:0] IDX_CONTRAST_GAIN = 10'h011;
   localparam logic [9:0] IDX_SHARPNESS_CONTROL = 10'h012;
   localparam logic [9:0] IDX_STANDARD_SELECT = 10'h01C;
   localparam logic [9:0] IDX_FIXED_GAIN = 10'h022;
   localparam logic [9:0] IDX_MISSING_COUNT = 10'h03F;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RST_INPUT_FORMAT = 8'h40;
   localparam logic [7:0] RST_ANALOG_CTRL = 8'h40;
   localparam logic [7:0] RST_CROP_HIGH = 8'h12;
   localparam logic [7:0] RST_VDELAY_LOW = 8'h12;
   localparam logic [7:0] RST_VACTIVE_LOW = 8'h20;
   localparam logic [7:0] RST_HDELAY_LOW = 8'h10;
   localparam logic [7:0] RST_HACTIVE_LOW = 8'hD0;
   localparam logic [7:0] RST_FILTER_CTRL = 8'hCC;
   localparam logic [7:0] RST_CAPTION_CTRL = 8'h15;
   localparam logic [7:0] RST_BRIGHTNESS = 8'h00;
   localparam logic [7:0] RST_CONTRAST = 8'h5C;
   localparam logic [7:0] RST_STANDARD = 8'h0F;
   localparam logic [7:0] RST_FIXED_GAIN = 8'hF0;
   localparam logic [7:0] RST_MISSING_COUNT = 8'h04;

   // ****************************************
   // Field positions and codes
   // ****************************************
   localparam int BIT_SOFT_RESET = 7;
   localparam int BIT_SHADOW_DISABLE = 3;
   localparam logic [2:0] STD_PAL_BDGHI = 3'h1;
   localparam logic [2:0] STD_SECAM = 3'h2;
   localparam logic [2:0] STD_PAL_M = 3'h4;
   localparam logic [2:0] STD_PAL_CN = 3'h5;
   localparam logic [2:0] STD_PAL_60 = 3'h6;
   localparam logic [2:0] STD_AUTO = 3'h7;
   localparam int CONTRAST_SHIFT = 6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : vdc_pkg
